// ### src/ccr_pkg.sv
// Purpose: Shared constants and carriers for the CPU core register and timing block.
// Assumes: One 20 MHz clock, synchronous active-low reset.
// Notes: Special-function addresses are byte addresses in the direct space.
package ccr_pkg;

  // Clock rate and clock period
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

  // Special-function addresses
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] ADDR_STACK_POINTER = 8'h81;
  localparam logic [7:0] ADDR_DATA_POINTER_LOW = 8'h82;
  localparam logic [7:0] ADDR_DATA_POINTER_HIGH = 8'h83;
  localparam logic [7:0] ADDR_PROGRAM_STATUS_WORD = 8'hD0;
  localparam logic [7:0] ADDR_MUL_DIV_AUX = 8'hF0;

  // Reset values
  localparam logic [7:0] RST_STACK_POINTER = 8'h07;
  localparam logic [7:0] RST_DATA_POINTER_LOW = 8'h00;
  localparam logic [7:0] RST_DATA_POINTER_HIGH = 8'h00;
  localparam logic [7:0] RST_PROGRAM_STATUS_WORD = 8'h00;
  localparam logic [7:0] RST_MUL_DIV_AUX = 8'h00;

  // Program status word bit positions
  localparam int BIT_CARRY = 7;
  localparam int BIT_AUX_CARRY = 6;
  localparam int BIT_USER_ZERO = 5;
  localparam int BIT_BANK_HIGH = 4;
  localparam int BIT_BANK_LOW = 3;
  localparam int BIT_RANGE = 2;
  localparam int BIT_USER_ONE = 1;
  localparam int BIT_ODD_ONES = 0;

  // Machine cycle figures
  localparam logic [4:0] CLKS_PER_MC_SLOW = 5'h0C;
  localparam logic [4:0] CLKS_PER_MC_FAST = 5'h06;
  localparam int RESET_HOLD_MC = 2;
  localparam logic [5:0] RESET_HOLD_SLOW = 6'(RESET_HOLD_MC * 12);
  localparam logic [5:0] RESET_HOLD_FAST = 6'(RESET_HOLD_MC * 6);

  // Instruction length codes
  localparam logic [1:0] LEN_ONE = 2'h0;
  localparam logic [1:0] LEN_TWO = 2'h1;
  localparam logic [1:0] LEN_FOUR = 2'h2;

  // Machine-cycle states
  typedef enum logic [2:0] {
    ST_S1 = 3'b000,
    ST_S2 = 3'b001,
    ST_S3 = 3'b010,
    ST_S4 = 3'b011,
    ST_S5 = 3'b100,
    ST_S6 = 3'b101
  } ccr_state_t;

  // Flag updates from the execution unit
  typedef struct packed {
    logic carry_we;
    logic carry;
    logic aux_carry_we;
    logic aux_carry;
    logic range_we;
    logic range;
  } ccr_flag_upd_t;

  // Timing strobes toward the core
  typedef struct packed {
    logic opcode_latch;
    logic second_fetch;
    logic mc_end;
    logic instr_done;
  } ccr_timing_t;

endpackage : ccr_pkg

// ### src/ccr_core_regs.sv
// Purpose: CPU status, pointer and auxiliary registers plus machine-cycle sequencing.
// Assumes: ccr_pkg compiled first; core drives the accumulator and flag updates.
// Notes: Direct special-function accesses only; indirect upper accesses go to RAM.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Status word at D0H, resets to zero, carry down to odd-ones bit.
// - The two bank bits pick one of four working register banks.
// - Odd-ones bit always follows the accumulator's count of one bits.
// - Carry is arithmetic carry and the Boolean accumulator bit.
// - Aux carry keeps nibble carry; range flag keeps arithmetic overflow.
// - Two user flags are free read/write, never touched by hardware.
// - Stack pointer at 81H, read/write, resets to 07H.
// - Data pointer low byte at 82H, read/write, resets to zero.
// - Data pointer high byte at 83H, read/write, resets to zero.
// - Multiply/divide helper at F0H, read/write, resets to zero.
// - A machine cycle lasts 12 or 6 clocks by cycle mode.
// - An instruction takes one, two or four machine cycles.
// - Six states per machine cycle, two one-clock phases each in slow mode, one clock each in fast mode.
// - Opcode latched in S1, second fetch in S4, done strobe in S6 of the last machine cycle.
// - External move writes change nothing; reads return zero.
// - Registers answer direct accesses only; indirect goes to upper RAM.
module ccr_core_regs (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic reset_pin_i,
  input wire logic fast_mode_i,
  input wire logic [1:0] instr_len_i,
  input wire logic [7:0] acc_i,
  input wire ccr_pkg::ccr_flag_upd_t flag_upd_i,
  input wire logic sp_inc_i,
  input wire logic sp_dec_i,
  input wire logic dptr_inc_i,
  input wire logic [2:0] reg_idx_i,
  input wire logic xmove_wr_i,
  input wire logic xmove_rd_i,
  input wire logic [7:0] mem_addr_i,
  input wire logic mem_direct_i,
  input wire logic mem_wr_i,
  input wire logic mem_rd_i,
  input wire logic [7:0] mem_wdata_i,
  output logic [7:0] mem_rdata_o,
  output logic mem_rd_ack_o,
  output logic sfr_hit_o,
  output logic upper_ram_sel_o,
  output logic [7:0] program_status_word_o,
  output logic [7:0] stack_pointer_o,
  output logic [15:0] data_pointer_o,
  output logic [7:0] mul_div_aux_o,
  output logic carry_o,
  output logic [4:0] bank_reg_addr_o,
  output logic [7:0] xmove_rdata_o,
  output logic [2:0] state_o,
  output logic phase_o,
  output ccr_pkg::ccr_timing_t timing_o,
  output logic core_reset_o
);

  // Odd count of one bits in a byte
  function automatic logic odd_ones(input logic [7:0] val);
    odd_ones = ^val;
  endfunction : odd_ones

  // Instruction length code to last machine-cycle index
  function automatic logic [1:0] last_mc(input logic [1:0] len);
    if (len == ccr_pkg::LEN_FOUR) begin
      last_mc = 2'h3;
    end else if (len == ccr_pkg::LEN_TWO) begin
      last_mc = 2'h1;
    end else begin
      last_mc = 2'h0;
    end
  endfunction : last_mc

  // Reset pin: three-stage synchroniser and hold counter
  logic [2:0] pin_sync_ff;
  logic pin_level_ff;
  logic [5:0] hold_cnt_ff;
  logic core_reset_ff;
  logic [2:0] nxt_pin_sync;
  logic nxt_pin_level;
  logic [5:0] nxt_hold_cnt;
  logic nxt_core_reset;
  logic rst_all;
  logic mode_fast_ff;

  assign rst_all = !nrst_i || core_reset_ff;

  // Pin level changes only when the second and third stages agree
  always_comb begin
    logic [5:0] need;
    need = mode_fast_ff ? ccr_pkg::RESET_HOLD_FAST : ccr_pkg::RESET_HOLD_SLOW;
    nxt_pin_sync = {pin_sync_ff[1:0], reset_pin_i};
    nxt_pin_level = pin_level_ff;
    if (pin_sync_ff[1] == pin_sync_ff[2]) begin
      nxt_pin_level = pin_sync_ff[2];
    end
    nxt_hold_cnt = hold_cnt_ff;
    nxt_core_reset = core_reset_ff;
    if (!pin_level_ff) begin
      nxt_hold_cnt = 6'h00;
      nxt_core_reset = 1'b0;
    end else if (hold_cnt_ff + 6'h01 >= need) begin
      nxt_core_reset = 1'b1;
    end else begin
      nxt_hold_cnt = hold_cnt_ff + 6'h01;
    end
  end

  // Synchroniser and hold counter registers
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      pin_sync_ff <= 3'h0;
      pin_level_ff <= 1'b0;
      hold_cnt_ff <= 6'h00;
      core_reset_ff <= 1'b0;
    end else begin
      pin_sync_ff <= nxt_pin_sync;
      pin_level_ff <= nxt_pin_level;
      hold_cnt_ff <= nxt_hold_cnt;
      core_reset_ff <= nxt_core_reset;
    end
  end

  // Machine-cycle sequencer
  ccr_pkg::ccr_state_t state_ff;
  ccr_pkg::ccr_state_t nxt_state;
  logic phase_ff;
  logic nxt_phase;
  logic [1:0] mc_idx_ff;
  logic [1:0] nxt_mc_idx;
  logic [1:0] last_ff;
  logic [1:0] nxt_last;
  logic nxt_mode_fast;
  ccr_pkg::ccr_timing_t timing_ff;
  ccr_pkg::ccr_timing_t nxt_timing;
  logic state_end;
  logic nxt_stamp;

  // Fast mode: one clock per state; slow mode: two phases per state
  assign state_end = mode_fast_ff || phase_ff;

  // Next state, phase and machine-cycle index
  always_comb begin
    nxt_state = state_ff;
    nxt_phase = phase_ff;
    nxt_mc_idx = mc_idx_ff;
    nxt_last = last_ff;
    nxt_mode_fast = mode_fast_ff;
    if (!state_end) begin
      nxt_phase = 1'b1;
    end else begin
      nxt_phase = 1'b0;
      case (state_ff)
        ccr_pkg::ST_S1: begin
          nxt_state = ccr_pkg::ST_S2;
          if (mc_idx_ff == 2'h0) begin
            nxt_last = last_mc(instr_len_i);
          end
        end
        ccr_pkg::ST_S2: nxt_state = ccr_pkg::ST_S3;
        ccr_pkg::ST_S3: nxt_state = ccr_pkg::ST_S4;
        ccr_pkg::ST_S4: nxt_state = ccr_pkg::ST_S5;
        ccr_pkg::ST_S5: nxt_state = ccr_pkg::ST_S6;
        ccr_pkg::ST_S6: begin
          nxt_state = ccr_pkg::ST_S1;
          nxt_mode_fast = fast_mode_i; // mode changes only at cycle edge
          if (mc_idx_ff == last_ff) begin
            nxt_mc_idx = 2'h0;
          end else begin
            nxt_mc_idx = mc_idx_ff + 2'h1;
          end
        end
        default: nxt_state = ccr_pkg::ST_S1;
      endcase
    end
  end

  // Strobes aligned to the clock in which their state's last phase runs
  always_comb begin
    nxt_stamp = nxt_mode_fast || nxt_phase;
    nxt_timing.opcode_latch = nxt_stamp && (nxt_state == ccr_pkg::ST_S1)
                              && (nxt_mc_idx == 2'h0);
    nxt_timing.second_fetch = nxt_stamp && (nxt_state == ccr_pkg::ST_S4)
                              && (nxt_mc_idx == 2'h0);
    nxt_timing.mc_end = nxt_stamp && (nxt_state == ccr_pkg::ST_S6);
    nxt_timing.instr_done = nxt_timing.mc_end && (nxt_mc_idx == nxt_last);
  end

  // Sequencer registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_all) begin
      state_ff <= ccr_pkg::ST_S1;
      phase_ff <= 1'b0;
      mc_idx_ff <= 2'h0;
      last_ff <= 2'h0;
      mode_fast_ff <= 1'b0;
      timing_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      phase_ff <= nxt_phase;
      mc_idx_ff <= nxt_mc_idx;
      last_ff <= nxt_last;
      mode_fast_ff <= nxt_mode_fast;
      timing_ff <= nxt_timing;
    end
  end

  // Architectural registers and direct access port
  logic [7:0] psw_ff;
  logic [7:0] sp_ff;
  logic [7:0] dpl_ff;
  logic [7:0] dph_ff;
  logic [7:0] aux_ff;
  logic [7:0] rdata_ff;
  logic rd_ack_ff;
  logic hit_ff;
  logic upper_ff;
  logic [4:0] bank_addr_ff;
  logic [7:0] nxt_psw;
  logic [7:0] nxt_sp;
  logic [7:0] nxt_dpl;
  logic [7:0] nxt_dph;
  logic [7:0] nxt_aux;
  logic [7:0] nxt_rdata;
  logic nxt_rd_ack;
  logic nxt_hit;
  logic nxt_upper;
  logic [4:0] nxt_bank_addr;
  logic xmove_seen_ff;
  logic nxt_xmove_seen;
  logic sfr_sel;
  logic wr_sel;

  // Only direct accesses in the upper half reach these registers
  assign sfr_sel = mem_direct_i && (mem_addr_i >= ccr_pkg::SFR_BASE);
  assign wr_sel = sfr_sel && mem_wr_i;

  // Register next values: software write first, hardware updates win
  always_comb begin
    nxt_psw = psw_ff;
    nxt_sp = sp_ff;
    nxt_dpl = dpl_ff;
    nxt_dph = dph_ff;
    nxt_aux = aux_ff;
    if (wr_sel && (mem_addr_i == ccr_pkg::ADDR_PROGRAM_STATUS_WORD)) begin
      nxt_psw = mem_wdata_i;
    end else if (wr_sel && (mem_addr_i == ccr_pkg::ADDR_STACK_POINTER)) begin
      nxt_sp = mem_wdata_i;
    end else if (wr_sel && (mem_addr_i == ccr_pkg::ADDR_DATA_POINTER_LOW)) begin
      nxt_dpl = mem_wdata_i;
    end else if (wr_sel && (mem_addr_i == ccr_pkg::ADDR_DATA_POINTER_HIGH)) begin
      nxt_dph = mem_wdata_i;
    end else if (wr_sel && (mem_addr_i == ccr_pkg::ADDR_MUL_DIV_AUX)) begin
      nxt_aux = mem_wdata_i;
    end
    // Execution flag results override a same-cycle software write
    if (flag_upd_i.carry_we) begin
      nxt_psw[ccr_pkg::BIT_CARRY] = flag_upd_i.carry;
    end
    if (flag_upd_i.aux_carry_we) begin
      nxt_psw[ccr_pkg::BIT_AUX_CARRY] = flag_upd_i.aux_carry;
    end
    if (flag_upd_i.range_we) begin
      nxt_psw[ccr_pkg::BIT_RANGE] = flag_upd_i.range;
    end
    // Odd-ones bit is never written, it tracks the accumulator
    nxt_psw[ccr_pkg::BIT_ODD_ONES] = odd_ones(acc_i);
    // Stack and pointer stepping by the core
    if (sp_inc_i && !sp_dec_i) begin
      nxt_sp = sp_ff + 8'h01;
    end else if (sp_dec_i && !sp_inc_i) begin
      nxt_sp = sp_ff - 8'h01;
    end
    if (dptr_inc_i) begin
      {nxt_dph, nxt_dpl} = {dph_ff, dpl_ff} + 16'h0001;
    end
    // External move writes reach nothing here
    if (xmove_wr_i) begin
      nxt_aux = nxt_aux;
    end
  end

  // Read data, decode flags and bank address
  always_comb begin
    nxt_rdata = 8'h00;
    nxt_hit = 1'b0;
    nxt_rd_ack = mem_rd_i;
    nxt_upper = !mem_direct_i && (mem_addr_i >= ccr_pkg::SFR_BASE);
    nxt_xmove_seen = xmove_rd_i;
    if (!sfr_sel) begin
      nxt_hit = 1'b0;
    end else if (mem_addr_i == ccr_pkg::ADDR_PROGRAM_STATUS_WORD) begin
      nxt_rdata = psw_ff;
      nxt_hit = 1'b1;
    end else if (mem_addr_i == ccr_pkg::ADDR_STACK_POINTER) begin
      nxt_rdata = sp_ff;
      nxt_hit = 1'b1;
    end else if (mem_addr_i == ccr_pkg::ADDR_DATA_POINTER_LOW) begin
      nxt_rdata = dpl_ff;
      nxt_hit = 1'b1;
    end else if (mem_addr_i == ccr_pkg::ADDR_DATA_POINTER_HIGH) begin
      nxt_rdata = dph_ff;
      nxt_hit = 1'b1;
    end else if (mem_addr_i == ccr_pkg::ADDR_MUL_DIV_AUX) begin
      nxt_rdata = aux_ff;
      nxt_hit = 1'b1;
    end
    if (!mem_rd_i) begin
      nxt_rdata = 8'h00;
    end
    // Working register address inside the selected bank
    nxt_bank_addr = {nxt_psw[ccr_pkg::BIT_BANK_HIGH], nxt_psw[ccr_pkg::BIT_BANK_LOW],
                     reg_idx_i};
  end

  // Architectural and port registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_all) begin
      psw_ff <= ccr_pkg::RST_PROGRAM_STATUS_WORD;
      sp_ff <= ccr_pkg::RST_STACK_POINTER;
      dpl_ff <= ccr_pkg::RST_DATA_POINTER_LOW;
      dph_ff <= ccr_pkg::RST_DATA_POINTER_HIGH;
      aux_ff <= ccr_pkg::RST_MUL_DIV_AUX;
      rdata_ff <= 8'h00;
      rd_ack_ff <= 1'b0;
      hit_ff <= 1'b0;
      upper_ff <= 1'b0;
      bank_addr_ff <= 5'h00;
      xmove_seen_ff <= 1'b0;
    end else begin
      psw_ff <= nxt_psw;
      sp_ff <= nxt_sp;
      dpl_ff <= nxt_dpl;
      dph_ff <= nxt_dph;
      aux_ff <= nxt_aux;
      rdata_ff <= nxt_rdata;
      rd_ack_ff <= nxt_rd_ack;
      hit_ff <= nxt_hit;
      upper_ff <= nxt_upper;
      bank_addr_ff <= nxt_bank_addr;
      xmove_seen_ff <= nxt_xmove_seen;
    end
  end

  // Outputs straight from flip-flops, except xmove_rdata_o, which is a constant zero
  assign mem_rdata_o = rdata_ff;
  assign mem_rd_ack_o = rd_ack_ff;
  assign sfr_hit_o = hit_ff;
  assign upper_ram_sel_o = upper_ff;
  assign program_status_word_o = psw_ff;
  assign stack_pointer_o = sp_ff;
  assign data_pointer_o = {dph_ff, dpl_ff};
  assign mul_div_aux_o = aux_ff;
  assign carry_o = psw_ff[ccr_pkg::BIT_CARRY];
  assign bank_reg_addr_o = bank_addr_ff;
  assign xmove_rdata_o = {8{1'b0}} & {8{xmove_seen_ff}}; // No data source, reads give zero
  assign state_o = state_ff;
  assign phase_o = phase_ff;
  assign timing_o = timing_ff;
  assign core_reset_o = core_reset_ff;

endmodule : ccr_core_regs

`default_nettype wire

// ### verification/ccr_core_regs_checker.sv
// Purpose: Port-level assertions for the CPU core register and timing block.
// Assumes: Sees only the ports of ccr_core_regs; one clock domain.
// Notes: Checks other than the reset-value check are off while the synchronous reset or the pin reset is active.
`timescale 1ns/100ps
`default_nettype none
module ccr_core_regs_checker (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic fast_mode_i,
  input wire logic [7:0] acc_i,
  input wire logic [2:0] reg_idx_i,
  input wire logic mem_direct_i,
  input wire logic mem_rd_i,
  input wire logic [7:0] mem_addr_i,
  input wire logic [7:0] mem_rdata_o,
  input wire logic mem_rd_ack_o,
  input wire logic sfr_hit_o,
  input wire logic upper_ram_sel_o,
  input wire logic [7:0] program_status_word_o,
  input wire logic [7:0] stack_pointer_o,
  input wire logic [15:0] data_pointer_o,
  input wire logic carry_o,
  input wire logic [4:0] bank_reg_addr_o,
  input wire logic [7:0] xmove_rdata_o,
  input wire logic phase_o,
  input wire logic [2:0] state_o,
  input wire ccr_pkg::ccr_timing_t timing_o,
  input wire logic core_reset_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i || core_reset_o);

  // Gaps between machine-cycle ends in each mode
  sequence slow_gap;
    !timing_o.mc_end [*8] ##1 !timing_o.mc_end [*3] ##1 timing_o.mc_end;
  endsequence
  sequence fast_gap;
    !timing_o.mc_end [*5] ##1 timing_o.mc_end;
  endsequence

  // Register, flag and timing relations
  chk_reset_values: assert property (disable iff (1'b0) !nrst_i |=>
    stack_pointer_o == 8'h07 && program_status_word_o == 8'h00 && data_pointer_o == 16'h0000)
    else $error("register reset value wrong");
  chk_parity_follow: assert property (1 |=> program_status_word_o[0] == ^$past(acc_i))
    else $error("odd-ones bit does not follow accumulator");
  chk_carry_mirror: assert property (carry_o == program_status_word_o[7])
    else $error("carry output differs from status bit 7");
  chk_bank_addr: assert property (1 |=>
    bank_reg_addr_o == {program_status_word_o[4:3], $past(reg_idx_i)})
    else $error("working register address wrong");
  chk_read_ack: assert property (1 |=> mem_rd_ack_o == $past(mem_rd_i))
    else $error("read acknowledge not one clock after request");
  chk_indirect_upper: assert property (mem_rd_i && !mem_direct_i && mem_addr_i[7] |=>
    mem_rdata_o == 8'h00 && !sfr_hit_o && upper_ram_sel_o)
    else $error("indirect access reached a register");
  chk_slow_cycle: assert property (timing_o.mc_end && !fast_mode_i |=> slow_gap)
    else $error("slow machine cycle not 12 clocks");
  chk_fast_cycle: assert property (timing_o.mc_end && fast_mode_i |=> fast_gap)
    else $error("fast machine cycle not 6 clocks");
  chk_fetch_slow: assert property (timing_o.opcode_latch && phase_o |->
    state_o == 3'h0 ##6 timing_o.second_fetch && state_o == 3'h3)
    else $error("slow second fetch misplaced");
  chk_fetch_fast: assert property (timing_o.opcode_latch && !phase_o |->
    state_o == 3'h0 ##3 timing_o.second_fetch && state_o == 3'h3)
    else $error("fast second fetch misplaced");
  chk_done_at_end: assert property (timing_o.instr_done |->
    timing_o.mc_end && state_o == 3'h5)
    else $error("instruction end not at S6");
  chk_xmove_zero: assert property (xmove_rdata_o == 8'h00)
    else $error("external move read data not zero");
endmodule : ccr_core_regs_checker

bind ccr_core_regs ccr_core_regs_checker u_chk (.ref_clk_i, .nrst_i, .fast_mode_i, .acc_i,
  .reg_idx_i, .mem_direct_i, .mem_rd_i, .mem_addr_i, .mem_rdata_o, .mem_rd_ack_o, .sfr_hit_o,
  .upper_ram_sel_o, .program_status_word_o, .stack_pointer_o, .data_pointer_o, .carry_o,
  .bank_reg_addr_o, .xmove_rdata_o, .phase_o, .state_o, .timing_o, .core_reset_o);
`default_nettype wire

// ### verification/ccr_core_regs_bench.sv
// Purpose: Self-checking bench for the CPU core register and timing block.
// Assumes: 20 MHz clock; reads are checked from a queue of expected values.
// Notes: Register data comes from a fixed random seed.
`timescale 1ns/100ps
`default_nettype none
module ccr_core_regs_bench;
  logic ref_clk_i, nrst_i, reset_pin_i, fast_mode_i, hit;
  logic [1:0] instr_len_i;
  logic [7:0] acc_i, mem_addr_i, mem_wdata_i, mem_rdata_o, program_status_word_o, av;
  ccr_pkg::ccr_flag_upd_t flag_upd_i;
  logic sp_inc_i, sp_dec_i, dptr_inc_i, xmove_wr_i, xmove_rd_i, carry_o, phase_o, core_reset_o;
  logic [2:0] reg_idx_i, state_o, idx;
  logic mem_direct_i, mem_wr_i, mem_rd_i, mem_rd_ack_o, sfr_hit_o, upper_ram_sel_o;
  logic [7:0] stack_pointer_o, mul_div_aux_o, xmove_rdata_o;
  logic [15:0] data_pointer_o;
  logic [4:0] bank_reg_addr_o;
  ccr_pkg::ccr_timing_t timing_o;
  logic [8:0] exp_q[$];
  logic [7:0] addrs [5];
  logic [7:0] v [5];
  int errors = 0;
  int total_checks = 0;
  int n;

  ccr_core_regs u_dut (.ref_clk_i, .nrst_i, .reset_pin_i, .fast_mode_i, .instr_len_i, .acc_i,
    .flag_upd_i, .sp_inc_i, .sp_dec_i, .dptr_inc_i, .reg_idx_i, .xmove_wr_i, .xmove_rd_i,
    .mem_addr_i, .mem_direct_i, .mem_wr_i, .mem_rd_i, .mem_wdata_i, .mem_rdata_o, .mem_rd_ack_o,
    .sfr_hit_o, .upper_ram_sel_o, .program_status_word_o, .stack_pointer_o, .data_pointer_o,
    .mul_div_aux_o, .carry_o, .bank_reg_addr_o, .xmove_rdata_o, .state_o, .phase_o, .timing_o,
    .core_reset_o);

  // Compare one value and count it
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  // One register-port request per clock, held until the next call
  task automatic op(input logic rd, input logic wr, input logic dir, input logic [7:0] a,
                    input logic [7:0] d, input logic [8:0] e);
    @(posedge ref_clk_i);
    mem_rd_i <= rd;
    mem_wr_i <= wr;
    mem_direct_i <= dir;
    mem_addr_i <= a;
    mem_wdata_i <= d;
    if (rd) exp_q.push_back(e);
  endtask : op
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    op(1'b1, 1'b0, 1'b1, a, 8'h00, {1'b1, e});
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(1'b0, 1'b1, 1'b1, a, d, 9'h000);
  endtask : wr
  task automatic idle();
    op(1'b0, 1'b0, 1'b1, 8'h00, 8'h00, 9'h000);
  endtask : idle

  // One-clock pointer step pulse {sp_inc, sp_dec, dptr_inc}
  task automatic step(input logic [2:0] s);
    @(posedge ref_clk_i);
    {sp_inc_i, sp_dec_i, dptr_inc_i} <= s;
    @(posedge ref_clk_i);
    {sp_inc_i, sp_dec_i, dptr_inc_i} <= 3'h0;
    @(negedge ref_clk_i);
  endtask : step

  // Status write with a same-clock hardware flag update, then read back
  task automatic flag_wr(input logic [7:0] wv, input logic [5:0] f, input logic [7:0] e);
    wr(addrs[4], wv);
    flag_upd_i <= f;
    idle();
    flag_upd_i <= 6'h00;
    rd(addrs[4], {e[7:1], ^av});
    idle();
  endtask : flag_wr

  // Bounded waits on the instruction end strobe and the pin reset output
  task automatic wait_done(output int cnt);
    cnt = 0;
    do begin
      @(negedge ref_clk_i);
      cnt++;
    end while (timing_o.instr_done !== 1'b1 && cnt < 200);
    if (cnt >= 200) begin
      errors++;
      end_sim();
    end
  endtask : wait_done
  task automatic wait_core(input logic lvl, output int cnt);
    cnt = 0;
    do begin
      @(negedge ref_clk_i);
      cnt++;
    end while (core_reset_o !== lvl && cnt < 100);
    if (cnt >= 100) begin
      errors++;
      end_sim();
    end
  endtask : wait_core

  task automatic fin(input string s);
    $display("test %s done", s);
  endtask : fin

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // Read results are matched to the oldest expectation
  always @(negedge ref_clk_i) begin
    if (mem_rd_ack_o === 1'b1) begin
      if (exp_q.size() == 0) check("spurious ack", 16'h0001, 16'h0000);
      else check("read data", 16'({sfr_hit_o, mem_rdata_o}), 16'(exp_q.pop_front()));
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    errors++;
    end_sim();
  end

  // Main sequence
  initial begin
    {nrst_i, reset_pin_i, fast_mode_i, instr_len_i, acc_i, flag_upd_i} = '0;
    {sp_inc_i, sp_dec_i, dptr_inc_i, reg_idx_i, xmove_wr_i, xmove_rd_i} = '0;
    {mem_addr_i, mem_direct_i, mem_wr_i, mem_rd_i, mem_wdata_i} = '0;
    addrs = '{ccr_pkg::ADDR_STACK_POINTER, ccr_pkg::ADDR_DATA_POINTER_LOW,
      ccr_pkg::ADDR_DATA_POINTER_HIGH, ccr_pkg::ADDR_MUL_DIV_AUX, ccr_pkg::ADDR_PROGRAM_STATUS_WORD};
    void'($urandom(82309));
    av = 8'h00;
    repeat (4) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rd(addrs[0], ccr_pkg::RST_STACK_POINTER);
    rd(addrs[1], ccr_pkg::RST_DATA_POINTER_LOW);
    rd(addrs[2], ccr_pkg::RST_DATA_POINTER_HIGH);
    rd(addrs[3], ccr_pkg::RST_MUL_DIV_AUX);
    rd(addrs[4], ccr_pkg::RST_PROGRAM_STATUS_WORD);
    op(1'b1, 1'b0, 1'b1, 8'h84, 8'h00, 9'h000);
    idle();
    fin("reset values");
    for (int i = 0; i < 4; i++) begin
      v[i] = 8'($urandom);
      wr(addrs[i], v[i]);
      rd(addrs[i], v[i]);
    end
    av = 8'($urandom);
    acc_i <= av;
    idle();
    v[4] = 8'($urandom);
    wr(addrs[4], v[4]);
    rd(addrs[4], {v[4][7:1], ^av});
    op(1'b0, 1'b1, 1'b0, addrs[0], ~v[0], 9'h000);
    op(1'b1, 1'b0, 1'b0, addrs[0], 8'h00, 9'h000);
    rd(addrs[0], v[0]);
    idle();
    @(negedge ref_clk_i);
    check("data pointer", data_pointer_o, {v[2], v[1]});
    fin("read write");
    flag_wr(8'h00, 6'h3F, 8'hC4);
    flag_wr(8'h22, 6'h2A, 8'h22);
    for (int b = 0; b < 4; b++) begin
      idx = 3'($urandom);
      wr(addrs[4], {3'h0, 2'(b), 3'h0});
      reg_idx_i <= idx;
      idle();
      @(negedge ref_clk_i);
      check("bank address", 16'(bank_reg_addr_o), 16'({2'(b), idx}));
    end
    fin("flags and banks");
    step(3'h4);
    check("stack up", 16'(stack_pointer_o), 16'(v[0] + 8'h01));
    step(3'h2);
    check("stack down", 16'(stack_pointer_o), 16'(v[0]));
    step(3'h6);
    check("stack both", 16'(stack_pointer_o), 16'(v[0]));
    wr(addrs[1], 8'hFF);
    wr(addrs[2], 8'h12);
    idle();
    step(3'h1);
    check("pointer carry", data_pointer_o, 16'h1300);
    @(posedge ref_clk_i);
    {xmove_wr_i, xmove_rd_i} <= 2'h3;
    mem_wdata_i <= 8'($urandom);
    @(posedge ref_clk_i);
    {xmove_wr_i, xmove_rd_i} <= 2'h0;
    @(negedge ref_clk_i);
    check("xmove pointer", data_pointer_o, 16'h1300);
    check("xmove stack", 16'(stack_pointer_o), 16'(v[0]));
    check("xmove aux", 16'(mul_div_aux_o), 16'(v[3]));
    fin("steps and external move");
    for (int m = 0; m < 2; m++) begin
      for (int l = 0; l < 3; l++) begin
        @(posedge ref_clk_i);
        fast_mode_i <= m[0];
        instr_len_i <= 2'(l);
        wait_done(n);
        wait_done(n);
        wait_done(n);
        check("instr clocks", 16'(n), 16'((m ? 6 : 12) << l));
      end
    end
    fin("timing");
    @(posedge ref_clk_i);
    fast_mode_i <= 1'b0;
    acc_i <= 8'h00;
    reg_idx_i <= 3'h0;
    wait_done(n);
    wait_done(n);
    @(posedge ref_clk_i);
    reset_pin_i <= 1'b1;
    hit = 1'b0;
    repeat (10) @(negedge ref_clk_i) hit = hit | (core_reset_o !== 1'b0);
    @(posedge ref_clk_i);
    reset_pin_i <= 1'b0;
    repeat (10) @(negedge ref_clk_i) hit = hit | (core_reset_o !== 1'b0);
    check("short pin pulse", 16'(hit), 16'h0000);
    @(posedge ref_clk_i);
    reset_pin_i <= 1'b1;
    wait_core(1'b1, n);
    check("pin hold", 16'(n >= 24 && n <= 30), 16'h0001);
    @(negedge ref_clk_i);
    check("pin reset stack", 16'(stack_pointer_o), 16'(ccr_pkg::RST_STACK_POINTER));
    check("pin reset pointer", data_pointer_o, 16'h0000);
    @(posedge ref_clk_i);
    reset_pin_i <= 1'b0;
    wait_core(1'b0, n);
    rd(addrs[3], ccr_pkg::RST_MUL_DIV_AUX);
    idle();
    repeat (3) @(negedge ref_clk_i);
    check("queue empty", 16'(exp_q.size()), 16'h0000);
    fin("reset pin");
    end_sim();
  end
endmodule : ccr_core_regs_bench
`default_nettype wire
